// >>> lbc_exec.sv
// lbc_exec: executes and/bit/test/clear/call on a prefetched word
// assumes program memory answers instr_word for prog_addr in-cycle
`timescale 1ns/100ps
module lbc_exec
    import lbc_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // program memory
    output logic [PC_W-1:0]        prog_addr,
    input  wire logic [IW-1:0]     instr_word,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata
);

    // ==========================================
    // helpers
    function automatic logic pick_bit(
        input logic [DATA_W-1:0] v,
        input logic [2:0]        b);
        pick_bit = v[b];
    endfunction

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == ZERO_BYTE);
    endfunction

    function automatic lbc_op_t decode(input logic [IW-1:0] w);
        lbc_op_t o;
        o = OP_NONE;
        if (w == ZERO_ACCUMULATOR_OP_WORD) begin
            o = OP_ZERO_ACCUMULATOR_OP;
        end else if (w[OPC_HI:OP6_LO] == OPC_ANDF) begin
            o = OP_ANDF;
        end else begin
            case (w[OPC_HI:OPC_LO])
                OPC_ANDI: o = OP_ANDI;
                OPC_BSET: o = OP_BSET;
                OPC_TZ:   o = OP_TZ; // RULE13
                OPC_TO:   o = OP_TO; // RULE14
                OPC_CALL: o = OP_CALL;
                default:  o = OP_NONE;
            endcase
        end
        decode = o;
    endfunction

    // ==========================================
    // state
    logic [PC_W-1:0]   pc_r,    pc_nxt;
    logic [IW-1:0]     ir_r,    ir_nxt;
    logic [DATA_W-1:0] acc_r,   acc_nxt;
    logic [DATA_W-1:0] stat_r,  stat_nxt;
    logic [DATA_W-1:0] ctrl_r,  ctrl_nxt;
    logic [DATA_W-1:0] rdat_r,  rdat_nxt;
    logic [DATA_W-1:0] file_r   [FILE_CNT];
    logic [DATA_W-1:0] file_nxt [FILE_CNT];
    logic [PC_W-1:0]   stk_r    [STACK_D];
    logic [PC_W-1:0]   stk_nxt  [STACK_D];

    lbc_op_t           op;
    logic              run;
    logic [F_HI:0]     f_sel;
    logic [2:0]        b_sel;
    logic [K_HI:0]     k_val;
    logic [DATA_W-1:0] file_rd;
    logic [DATA_W-1:0] andi_res;
    logic [DATA_W-1:0] andf_res;
    logic              tbit;
    logic              skip;

    assign op       = decode(ir_r);
    assign run      = ctrl_r[CTRL_RUN];
    assign f_sel    = ir_r[F_HI:0];
    assign b_sel    = ir_r[BIT_HI:BIT_LO];
    assign k_val    = ir_r[K_HI:0];
    assign file_rd  = file_r[f_sel];
    assign andi_res = acc_r & k_val;
    assign andf_res = acc_r & file_rd;
    assign tbit     = pick_bit(file_rd, b_sel);
    assign skip     = run && (((op == OP_TZ) && !tbit) ||
                              ((op == OP_TO) && tbit));

    assign prog_addr = pc_r;
    assign reg_rdata = rdat_r;

    // ==========================================
    // core next state
    // bus writes land first; a running instruction then overrides
    // them, so the core never loses its own result
    always_comb begin
        pc_nxt   = pc_r;
        ir_nxt   = ir_r;
        acc_nxt  = acc_r;
        stat_nxt = stat_r;
        ctrl_nxt = ctrl_r;
        file_nxt = file_r;
        stk_nxt  = stk_r;
        if (reg_wr) begin
            if (!reg_addr[ADDR_W-1]) begin
                file_nxt[reg_addr[F_HI:0]] = reg_wdata;
            end else begin
                case (reg_addr)
                    A_ACC:  acc_nxt  = reg_wdata;
                    A_STAT: stat_nxt = reg_wdata;
                    A_CTRL: ctrl_nxt = reg_wdata;
                    A_PCL: begin
                        pc_nxt[PCL_HI:0] = reg_wdata;
                        ir_nxt = NOP_WORD;
                    end
                    A_PCH: begin
                        pc_nxt[PC_W-1:PCH_LO] =
                            reg_wdata[PC_W-PCH_LO-1:0];
                        ir_nxt = NOP_WORD;
                    end
                    default: ;
                endcase
            end
        end
        if (run) begin
            ir_nxt = instr_word;
            pc_nxt = pc_r + PC_STEP; // RULE16
            case (op)
                OP_ANDI: begin
                    acc_nxt = andi_res; // RULE1
                    stat_nxt[Z_BIT] = is_zero(andi_res); // RULE15
                end
                OP_ANDF: begin
                    if (ir_r[DEST_B]) begin
                        file_nxt[f_sel] = andf_res; // RULE3
                    end else begin
                        acc_nxt = andf_res; // RULE2
                    end
                    stat_nxt[Z_BIT] = is_zero(andf_res); // RULE15
                end
                OP_ZERO_ACCUMULATOR_OP: begin
                    acc_nxt = ZERO_BYTE; // RULE8
                    stat_nxt[Z_BIT] = 1'b1;
                end
                OP_BSET: begin
                    file_nxt[f_sel][b_sel] = 1'b1; // RULE4
                end
                OP_TZ, OP_TO: begin
                    // RULE5 RULE6
                    if (skip) begin
                        ir_nxt = NOP_WORD; // RULE7
                    end
                end
                OP_CALL: begin
                    for (int i = STACK_D - 1; i > 0; i--) begin
                        stk_nxt[i] = stk_r[i-1];
                    end
                    stk_nxt[0] = pc_r; // RULE9
                    pc_nxt = {stat_r[PG_HI:PG_LO], 1'b0,
                              k_val}; // RULE10 RULE11
                    ir_nxt = NOP_WORD; // RULE12
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pc_r   <= RST_PC;
            ir_r   <= NOP_WORD;
            acc_r  <= ZERO_BYTE;
            stat_r <= ZERO_BYTE;
            ctrl_r <= ZERO_BYTE;
            for (int i = 0; i < FILE_CNT; i++) begin
                file_r[i] <= ZERO_BYTE;
            end
            for (int i = 0; i < STACK_D; i++) begin
                stk_r[i] <= RST_PC;
            end
        end else begin
            pc_r   <= pc_nxt;
            ir_r   <= ir_nxt;
            acc_r  <= acc_nxt;
            stat_r <= stat_nxt;
            ctrl_r <= ctrl_nxt;
            file_r <= file_nxt;
            stk_r  <= stk_nxt;
        end
    end

    // ==========================================
    // read port
    // data stand only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdat_nxt = ZERO_BYTE;
        if (reg_rd) begin
            if (!reg_addr[ADDR_W-1]) begin
                rdat_nxt = file_r[reg_addr[F_HI:0]];
            end else begin
                case (reg_addr)
                    A_ACC:  rdat_nxt = acc_r;
                    A_STAT: rdat_nxt = stat_r;
                    A_CTRL: rdat_nxt = ctrl_r;
                    A_PCL:  rdat_nxt = pc_r[PCL_HI:0];
                    A_PCH:  rdat_nxt[PC_W-PCH_LO-1:0] =
                                pc_r[PC_W-1:PCH_LO];
                    A_S0L:  rdat_nxt = stk_r[0][PCL_HI:0];
                    A_S0H:  rdat_nxt[PC_W-PCH_LO-1:0] =
                                stk_r[0][PC_W-1:PCH_LO];
                    A_S1L:  rdat_nxt = stk_r[1][PCL_HI:0];
                    A_S1H:  rdat_nxt[PC_W-PCH_LO-1:0] =
                                stk_r[1][PC_W-1:PCH_LO];
                    default: rdat_nxt = ZERO_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rdat_r <= ZERO_BYTE;
        end else begin
            rdat_r <= rdat_nxt;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    AST_ANDI_ACC: assert property ( // RULE1
        run && op == OP_ANDI |=> acc_r == $past(acc_r & k_val))
        else $error("literal and result wrong");

    AST_ANDF_ACC: assert property ( // RULE2
        run && op == OP_ANDF && !ir_r[DEST_B]
        |=> acc_r == $past(andf_res))
        else $error("register and to accumulator wrong");

    AST_ANDF_FILE: assert property ( // RULE3
        run && op == OP_ANDF && ir_r[DEST_B]
        |=> file_r[$past(f_sel)] == $past(andf_res)
            && $stable(acc_r))
        else $error("register and write-back wrong");

    AST_BSET: assert property ( // RULE4
        run && op == OP_BSET && !reg_wr
        |=> file_r[$past(f_sel)] == ($past(file_rd) |
            (8'h01 << $past(b_sel))) && $stable(stat_r))
        else $error("bit set wrong");

    AST_TZ_SKIP: assert property ( // RULE5
        run && op == OP_TZ && !tbit && !reg_wr
        |=> ir_r == NOP_WORD && $stable(stat_r))
        else $error("skip on zero missing");

    AST_TO_SKIP: assert property ( // RULE6
        run && op == OP_TO && tbit && !reg_wr
        |=> ir_r == NOP_WORD && $stable(stat_r))
        else $error("skip on one missing");

    AST_NO_SKIP: assert property ( // RULE7
        run && (op == OP_TZ || op == OP_TO) && !skip
        |=> ir_r == $past(instr_word))
        else $error("untaken skip dropped a word");

    AST_ZERO_ACCUMULATOR_OP: assert property ( // RULE8
        run && op == OP_ZERO_ACCUMULATOR_OP
        |=> acc_r == ZERO_BYTE && stat_r[Z_BIT])
        else $error("clear accumulator wrong");

    AST_CALL_PUSH: assert property ( // RULE9
        run && op == OP_CALL
        |=> stk_r[0] == $past(pc_r) && stk_r[1] == $past(stk_r[0]))
        else $error("call return address wrong");

    AST_CALL_PC: assert property ( // RULE11
        run && op == OP_CALL
        |=> pc_r == {$past(stat_r[PG_HI:PG_LO]), 1'b0,
                     $past(k_val)})
        else $error("call target wrong");

    AST_CALL_TWO: assert property ( // RULE12
        run && op == OP_CALL && !reg_wr
        |=> ir_r == NOP_WORD && $stable(stat_r)
        ##1 ($past(run) -> pc_r == $past(pc_r) + PC_STEP))
        else $error("call not two cycles");

    AST_ZERO_FLAG: assert property ( // RULE15
        run && (op == OP_ANDI || op == OP_ANDF)
        |=> stat_r[Z_BIT] == $past(op == OP_ANDI ?
            is_zero(andi_res) : is_zero(andf_res)))
        else $error("zero flag wrong");

    AST_ONE_CYCLE: assert property ( // RULE16
        run && (op == OP_ANDI || op == OP_BSET || op == OP_ZERO_ACCUMULATOR_OP)
        |=> pc_r == $past(pc_r) + PC_STEP
            && ir_r == $past(instr_word))
        else $error("single-cycle op stalled");

    COV_CALL: cover property (run && op == OP_CALL);
    COV_TZ_SKIP: cover property (run && op == OP_TZ && skip);
    COV_TO_SKIP: cover property (run && op == OP_TO && skip);
    COV_ANDF_FILE: cover property (
        run && op == OP_ANDF && ir_r[DEST_B]);

endmodule // lbc_exec

// >>> lbc_pkg.sv
// lbc_pkg: constants, opcodes, register offsets for the logic/bit/call core
// assumes a single 50 MHz clk_sys domain and a 12-bit instruction word
// What this block does
// RULE1 - literal AND into accumulator, zero flag only
// RULE2 - register AND into accumulator when dest clear
// RULE3 - dest set writes AND result to register
// RULE4 - bit set forces one bit, flags untouched
// RULE5 - skip next when tested bit is zero
// RULE6 - skip next when tested bit is one
// RULE7 - taken skip replaces prefetched word with no-op
// RULE8 - clear accumulator to zero, set zero flag
// RULE9 - call pushes incremented address onto stack
// RULE10 - call loads operand into address bits 7:0
// RULE11 - page bits to 10:9, bit 8 cleared
// RULE12 - call takes two cycles, flags untouched
// RULE13 - test-if-zero opcode top nibble 0110
// RULE14 - test-if-one opcode top nibble 0111
// RULE15 - zero flag set exactly when result zero
// RULE16 - other listed instructions take one cycle
package lbc_pkg;
    // ==========================================
    // widths and depths
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned FILE_CNT = 32;
    localparam int unsigned PC_W     = 11;
    localparam int unsigned IW       = 12;
    localparam int unsigned ADDR_W   = 6;
    localparam int unsigned STACK_D  = 2;
    // ==========================================
    // instruction fields
    localparam int unsigned OPC_HI  = 11;
    localparam int unsigned OPC_LO  = 8;
    localparam int unsigned OP6_LO  = 6;
    localparam int unsigned DEST_B  = 5;
    localparam int unsigned BIT_HI  = 7;
    localparam int unsigned BIT_LO  = 5;
    localparam int unsigned F_HI    = 4;
    localparam int unsigned K_HI    = 7;
    localparam int unsigned PCL_HI  = 7;
    localparam int unsigned PCH_LO  = 8;
    localparam logic [3:0]  OPC_ANDI = 4'hE;
    localparam logic [3:0]  OPC_BSET = 4'h5;
    localparam logic [3:0]  OPC_TZ   = 4'h6;
    localparam logic [3:0]  OPC_TO   = 4'h7;
    localparam logic [3:0]  OPC_CALL = 4'h9;
    localparam logic [5:0]  OPC_ANDF = 6'h05;
    localparam logic [11:0] NOP_WORD  = 12'h000;
    localparam logic [11:0] ZERO_ACCUMULATOR_OP_WORD = 12'h040;
    // ==========================================
    // status and control fields, reset values
    localparam int unsigned Z_BIT    = 2;
    localparam int unsigned PG_HI    = 6;
    localparam int unsigned PG_LO    = 5;
    localparam int unsigned CTRL_RUN = 0;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;
    localparam logic [10:0] RST_PC    = 11'h000;
    localparam logic [10:0] PC_STEP   = 11'h001;
    // ==========================================
    // register port offsets
    localparam logic [5:0] A_ACC  = 6'h20;
    localparam logic [5:0] A_STAT = 6'h21;
    localparam logic [5:0] A_PCL  = 6'h22;
    localparam logic [5:0] A_PCH  = 6'h23;
    localparam logic [5:0] A_CTRL = 6'h24;
    localparam logic [5:0] A_S0L  = 6'h25;
    localparam logic [5:0] A_S0H  = 6'h26;
    localparam logic [5:0] A_S1L  = 6'h27;
    localparam logic [5:0] A_S1H  = 6'h28;
    // ==========================================
    // decoded operations
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ANDI = 3'b001,
        OP_ANDF = 3'b010,
        OP_ZERO_ACCUMULATOR_OP = 3'b011,
        OP_BSET = 3'b100,
        OP_TZ   = 3'b101,
        OP_TO   = 3'b110,
        OP_CALL = 3'b111
    } lbc_op_t;
endpackage

// >>> lbc_prog_mem.sv
// lbc_prog_mem: program memory model feeding the core's fetch port
// assumes a combinational read and a clocked load port owned by the bench
`timescale 1ns/100ps
module lbc_prog_mem
    import lbc_pkg::*;
(
    // clock
    input  wire logic            clk_sys,
    // fetch port
    input  wire logic [PC_W-1:0] prog_addr,
    output logic [IW-1:0]        instr_word,
    // load port
    input  wire logic            ld_en,
    input  wire logic [PC_W-1:0] ld_addr,
    input  wire logic [IW-1:0]   ld_word
);
    // ==========================================
    // storage
    // erased cells read all ones, an undecoded word, so a stray fetch
    // never looks like a harmless all-zero no-op by accident
    logic [IW-1:0] mem [2**PC_W];
    initial begin
        for (int i = 0; i < 2**PC_W; i++) begin
            mem[i] = 12'hFFF;
        end
    end
    always @(posedge clk_sys) begin
        if (ld_en) begin
            mem[ld_addr] <= ld_word;
        end
    end
    assign instr_word = mem[prog_addr];
endmodule // lbc_prog_mem

// >>> cpu_logic_bit_call_execute_tb.sv
// cpu_logic_bit_call_execute_tb: random programs through the core
// assumes lbc_exec with lbc_prog_mem on its fetch port, one 50 MHz clock
`timescale 1ns/100ps
module cpu_logic_bit_call_execute_tb
    import lbc_pkg::*;
;
    // ==========================================
    // signals
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic [PC_W-1:0]   prog_addr;
    logic [IW-1:0]     instr_word;
    logic [ADDR_W-1:0] reg_addr = 6'h00;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              ld_en = 1'b0;
    logic [PC_W-1:0]   ld_addr = 11'h000;
    logic [IW-1:0]     ld_word = 12'h000;
    int                seed = 85424;
    int                miscompares = 0;
    int                n_tests = 0;
    always #10 clk_sys = ~clk_sys;
    lbc_exec i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .prog_addr(prog_addr), .instr_word(instr_word),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    lbc_prog_mem i_mem (.clk_sys(clk_sys), .prog_addr(prog_addr),
        .instr_word(instr_word), .ld_en(ld_en), .ld_addr(ld_addr),
        .ld_word(ld_word));
    // ==========================================
    // bus tasks and expectations
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        n_tests++;
        if ((reg_rdata & m) !== (e & m)) begin
            miscompares++;
            $display("unexpected %0t: reg %h got %h want %h",
                     $time, a, reg_rdata, e);
        end
    endtask
    task automatic ld(input logic [10:0] a, input logic [11:0] w);
        @(posedge clk_sys);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_word <= w;
        @(posedge clk_sys);
        ld_en <= 1'b0;
    endtask
    // restart at address 0, run until the fetch address hits stop, halt
    task automatic run(input logic [10:0] stop);
        bit hit;
        hit = 1'b0;
        wr(A_PCL, 8'h00);
        wr(A_PCH, 8'h00);
        wr(A_CTRL, 8'h01);
        for (int i = 0; i < 64 && !hit; i++) begin
            @(posedge clk_sys);
            #1;
            hit = (prog_addr === stop);
        end
        n_tests++;
        if (!hit) begin
            miscompares++;
            $display("unexpected %0t: fetch never reached %h", $time, stop);
        end
        wr(A_CTRL, 8'h00);
    endtask
    function automatic logic [7:0] set_if(logic [7:0] v, logic [2:0] b,
                                          logic en);
        return en ? (v | (8'h01 << b)) : v;
    endfunction
    // ==========================================
    // watchdog and main sequence
    initial begin
        #(20 * 20000);
        miscompares++;
        $display("unexpected %0t: watchdog expired", $time);
        end_sim();
    end
    initial begin
        logic [7:0]  a, k, k2, v2, v3, v4, v5, v6, r1, r2;
        logic [4:0]  f2, f3, f4, f5, f6;
        logic [2:0]  b3, b4, b5, b6;
        logic [1:0]  pg;
        logic [10:0] tgt;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(A_ACC, 8'hFF, 8'h00);
        rd(A_CTRL, 8'hFF, 8'h00);
        rd(6'h3F, 8'hFF, 8'h00);
        @(posedge clk_sys);
        #1;
        n_tests++;
        if (reg_rdata !== 8'h00) begin
            miscompares++;
            $display("unexpected %0t: read data held too long", $time);
        end
        $display("reset and register port test done");
        wr(A_ACC, 8'hFF);
        wr(6'h09, 8'h81);
        ld(11'h000, {OPC_ANDF, 1'b0, 5'h09});
        run(11'h003);
        rd(A_ACC, 8'hFF, 8'h81);
        rd(A_STAT, 8'h04, 8'h00);
        ld(11'h000, ZERO_ACCUMULATOR_OP_WORD);
        run(11'h003);
        rd(A_ACC, 8'hFF, 8'h00);
        rd(A_STAT, 8'h04, 8'h04);
        rd(6'h09, 8'hFF, 8'h81);
        $display("and and clear corner test done");
        for (int i = 0; i < 30; i++) begin
            a = 8'($random(seed));
            k = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            k2 = 8'h10 | 8'($random(seed));
            pg = 2'($random(seed));
            {v2, v3, v4, v5} = 32'($random(seed));
            v6 = 8'($random(seed));
            {b3, b4, b5, b6} = 12'($random(seed));
            f2 = 5'(($random(seed) & 32'h7FFF) % 6);
            f3 = 5'd6 + 5'(($random(seed) & 32'h7FFF) % 6);
            f4 = 5'd12 + 5'(($random(seed) & 32'h7FFF) % 6);
            f5 = 5'd18 + 5'(($random(seed) & 32'h7FFF) % 6);
            f6 = 5'd24 + 5'(($random(seed) & 32'h7FFF) % 8);
            wr(A_ACC, a);
            wr(A_STAT, {1'b0, pg, 5'h00});
            wr({1'b0, f2}, v2);
            wr({1'b0, f3}, v3);
            wr({1'b0, f4}, v4);
            wr({1'b0, f5}, v5);
            wr({1'b0, f6}, v6);
            ld(11'h000, {OPC_ANDI, k});
            ld(11'h001, {OPC_ANDF, 1'b1, f2});
            ld(11'h002, {OPC_BSET, b3, f3});
            ld(11'h003, {OPC_TZ, b4, f4});
            ld(11'h004, {OPC_BSET, b5, f5});
            ld(11'h005, {OPC_TO, b4, f4});
            ld(11'h006, {OPC_BSET, b6, f6});
            ld(11'h007, {OPC_CALL, k2});
            tgt = {pg, 1'b0, k2};
            r1 = a & k;
            r2 = r1 & v2;
            run(tgt + 11'd2);
            rd(A_ACC, 8'hFF, r1);
            rd(A_STAT, 8'h64, {1'b0, pg, 2'b00, r2 == 8'h00, 2'b00});
            rd({1'b0, f2}, 8'hFF, r2);
            rd({1'b0, f3}, 8'hFF, set_if(v3, b3, 1'b1));
            rd({1'b0, f4}, 8'hFF, v4);
            rd({1'b0, f5}, 8'hFF, set_if(v5, b5, v4[b4]));
            rd(A_S1L, 8'hFF, (i == 0) ? 8'h00 : 8'h08);
            rd({1'b0, f6}, 8'hFF, set_if(v6, b6, !v4[b4]));
            rd(A_S0L, 8'hFF, 8'h08);
            rd(A_S0H, 8'h07, 8'h00);
            $display("random program %0d done", i);
        end
        end_sim();
    end
endmodule // cpu_logic_bit_call_execute_tb
